// *** design/sram_host_pkg.sv ***
// package: constants, timing counts and carrier types for the byte-lane sram host controller
package sram_host_pkg;

  // =====================================================================
  // geometry
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 16;
  localparam int LANE_W      = 8;

  // =====================================================================
  // timing at the 20 MHz system clock
  localparam int CLK_PERIOD_NS     = 50;
  localparam int CLK_FREQ_HZ       = 20_000_000;
  // access phase lengths, ns (least times: rounded up)
  localparam int T_SETUP_NS        = 50;    // address/data settle before strobe
  localparam int T_STROBE_NS       = 100;   // strobe low time, covers slowest grade
  localparam int T_HOLD_NS         = 50;    // control and data hold after strobe
  localparam int SETUP_CYC         = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC        = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC          = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // retention recovery, ms; 5 ms is 100000 cycles
  localparam int T_RECOVERY_MS     = 5;
  localparam int RECOVERY_CYC      = T_RECOVERY_MS * (CLK_FREQ_HZ / 1000);

  // =====================================================================
  // carriers
  typedef struct packed {
    logic              write;      // 1 write, 0 read
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        lanes;      // [0] lower byte, [1] upper byte, active high
  } sram_req_t;

  typedef struct packed {
    logic              chip_select;
    logic              lower_lane_select_n;
    logic              upper_lane_select_n;
    logic              write_strobe_n;
    logic              output_enable_n;
  } sram_ctrl_t;

  localparam sram_ctrl_t CTRL_IDLE = '{chip_select: 1'b0, lower_lane_select_n: 1'b1,
                                       upper_lane_select_n: 1'b1, write_strobe_n: 1'b1,
                                       output_enable_n: 1'b1};

endpackage

// *** design/sram_host.sv ***
// host controller driving a 64K x 16 asynchronous static ram with byte lane selects
`timescale 1ns/1ps
// Functional notes
// RL1 - write when strobe low, chip and lane selected
// RL2 - address stable before and through whole write
// RL3 - data captured at first trailing control edge
// RL4 - output enable high keeps ram outputs off
// RL5 - read: strobe high, oe low, selected
// RL6 - lower select high: upper lane only
// RL7 - upper select high: lower lane only
// RL8 - deselected ram ignores access, floats outputs
// RL9 - strobe before select keeps outputs floating
// RL10 - host never drives bus during reads
// RL11 - deselected ram keeps data at low supply
// RL12 - deselect before supply reduction begins
// RL13 - stay deselected for recovery after supply returns
// RL14 - strobe low means write, oe ignored
module sram_host
  import sram_host_pkg::*;
#(
  parameter int RECOVERY_CYCLES = RECOVERY_CYC
)(
  // clock and reset
  input  wire logic                          i_clock,
  input  wire logic                          i_resetn,
  // request side
  input  wire logic                          i_req_valid,
  input  wire sram_host_pkg::sram_req_t      i_req,
  output logic                               o_req_ready,
  output logic                               o_rsp_valid,
  output logic [sram_host_pkg::DATA_W-1:0]   o_rsp_data,
  // retention control
  input  wire logic                          i_retention_req,
  output logic                               o_retention_ack,
  // memory pins
  output logic [sram_host_pkg::ADDR_W-1:0]   o_mem_addr,
  output sram_host_pkg::sram_ctrl_t          o_mem_ctrl,
  input  wire logic [sram_host_pkg::DATA_W-1:0] i_mem_dq,
  output logic [sram_host_pkg::DATA_W-1:0]   o_mem_dq,
  output logic [1:0]                         o_mem_dq_oe_n
);
  import sram_host_pkg::*;

  // =====================================================================
  // elaboration checks
  if (RECOVERY_CYCLES < 1)
  begin : g_bad_recovery
    $error("RECOVERY_CYCLES must be at least one");
  end

  typedef enum logic [2:0] {ST_RECOVER, ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RETAIN} state_t;

  localparam int CNT_W = $clog2(RECOVERY_CYCLES + 1) > 3 ? $clog2(RECOVERY_CYCLES + 1) : 3;

  state_t             state_ff;
  logic [CNT_W-1:0]   cnt_ff;
  sram_req_t          req_ff;
  logic [DATA_W-1:0]  dq_sync1_ff;
  logic [DATA_W-1:0]  dq_sync2_ff;
  logic               ret_sync1_ff;
  logic               ret_sync2_ff;
  logic               cnt_done;

  assign cnt_done = (cnt_ff == '0);

  // =====================================================================
  // input synchronisers: read data and retention request come from outside
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      dq_sync1_ff  <= '0;
      dq_sync2_ff  <= '0;
      ret_sync1_ff <= 1'b0;
      ret_sync2_ff <= 1'b0;
    end
    else
    begin
      dq_sync1_ff  <= i_mem_dq;
      dq_sync2_ff  <= dq_sync1_ff;
      ret_sync1_ff <= i_retention_req;
      ret_sync2_ff <= ret_sync1_ff;
    end
  end

  // =====================================================================
  // access sequencer; after reset the ram may be returning from low supply,
  // so the controller starts in recovery with the chip deselected
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_ff <= ST_RECOVER;
      cnt_ff   <= CNT_W'(RECOVERY_CYCLES - 1);
    end
    else
    begin
      unique case (state_ff)
        ST_RECOVER:
        begin
          if (cnt_done)
          begin
            state_ff <= ST_IDLE;                        // see RL13
          end
          else
          begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        ST_IDLE:
        begin
          if (ret_sync2_ff)
          begin
            state_ff <= ST_RETAIN;                      // see RL12
          end
          else if (i_req_valid && (i_req.lanes != 2'b00))
          begin
            state_ff <= ST_SETUP;
            cnt_ff   <= CNT_W'(SETUP_CYC - 1);
          end
        end
        ST_SETUP:
        begin
          if (cnt_done)
          begin
            state_ff <= ST_STROBE;
            cnt_ff   <= CNT_W'(STROBE_CYC - 1);
          end
          else
          begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        ST_STROBE:
        begin
          if (cnt_done)
          begin
            state_ff <= ST_HOLD;
            cnt_ff   <= CNT_W'(HOLD_CYC - 1);
          end
          else
          begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        ST_HOLD:
        begin
          if (cnt_done)
          begin
            state_ff <= ST_IDLE;
          end
          else
          begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        ST_RETAIN:
        begin
          if (!ret_sync2_ff)
          begin
            state_ff <= ST_RECOVER;                     // see RL13
            cnt_ff   <= CNT_W'(RECOVERY_CYCLES - 1);
          end
        end
      endcase
    end
  end

  // =====================================================================
  // request capture; address and data stay frozen for the whole access
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      req_ff <= '0;
    end
    else if (state_ff == ST_IDLE && !ret_sync2_ff && i_req_valid)
    begin
      req_ff <= i_req;                                  // see RL2
    end
  end

  // =====================================================================
  // read data: taken at the end of hold, when the synchroniser holds the bus as it
  // stood one cycle after output enable fell; this costs latency but keeps
  // metastability out of the result
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rsp_valid <= 1'b0;
      o_rsp_data  <= '0;
    end
    else
    begin
      o_rsp_valid <= 1'b0;
      if (state_ff == ST_HOLD && cnt_done && !req_ff.write)
      begin
        o_rsp_valid <= 1'b1;
        // unselected lanes float on the ram side, so report them as zero
        o_rsp_data  <= {req_ff.lanes[1] ? dq_sync2_ff[DATA_W-1:LANE_W] : 8'h00,
                        req_ff.lanes[0] ? dq_sync2_ff[LANE_W-1:0]      : 8'h00};
      end
    end
  end

  // =====================================================================
  // pin drive, all from flip-flops
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_mem_addr    <= '0;
      o_mem_ctrl    <= CTRL_IDLE;
      o_mem_dq      <= '0;
      o_mem_dq_oe_n <= 2'b11;
    end
    else
    begin
      o_mem_ctrl    <= CTRL_IDLE;                       // see RL8
      o_mem_dq_oe_n <= 2'b11;
      o_mem_addr    <= req_ff.addr;                     // see RL2
      o_mem_dq      <= req_ff.wdata;
      if (state_ff == ST_SETUP || state_ff == ST_STROBE || state_ff == ST_HOLD)
      begin
        // selects held across setup, strobe and hold; strobe only in the middle
        o_mem_ctrl.chip_select         <= 1'b1;
        o_mem_ctrl.lower_lane_select_n <= ~req_ff.lanes[0];   // see RL7
        o_mem_ctrl.upper_lane_select_n <= ~req_ff.lanes[1];   // see RL6
        if (req_ff.write)
        begin
          // strobe low for the whole strobe phase only: selects lead it by the setup
          // phase and outlast it by the hold phase, so the strobe edge ends the write;
          // see RL3, RL9
          o_mem_ctrl.write_strobe_n <= ~(state_ff == ST_STROBE);   // see RL1
          o_mem_ctrl.output_enable_n <= 1'b1;           // see RL4, RL14
          o_mem_dq_oe_n <= ~req_ff.lanes;               // drive selected lanes only
        end
        else
        begin
          o_mem_ctrl.write_strobe_n  <= 1'b1;           // see RL5
          o_mem_ctrl.output_enable_n <= ~(state_ff == ST_STROBE || (state_ff == ST_SETUP && cnt_done));
          o_mem_dq_oe_n <= 2'b11;                       // see RL10
        end
      end
    end
  end

  // =====================================================================
  // handshake outputs
  assign o_req_ready     = (state_ff == ST_IDLE) && !ret_sync2_ff;
  assign o_retention_ack = (state_ff == ST_RETAIN);     // see RL11, RL12

endmodule // sram_host

// *** test/sram_model.sv ***
// behavioural byte-lane static ram as seen from its pins
`timescale 1ns/1ps
module sram_model
  import sram_host_pkg::*;
(
  // pins from the host
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire sram_ctrl_t        i_ctrl,
  input  wire logic [DATA_W-1:0] i_dq,
  input  wire logic [1:0]        i_dq_oe_n,
  // resolved bus level
  output logic      [DATA_W-1:0] o_bus
);
  logic [DATA_W-1:0] mem [0:65535];
  logic [DATA_W-1:0] lat_d;
  logic [1:0]        sel;
  logic [1:0]        lat_l;
  logic              wr;
  logic              rd;
  // lane enables; chip select low or both selects high ignores all
  assign sel = {~i_ctrl.upper_lane_select_n, ~i_ctrl.lower_lane_select_n} & {2{i_ctrl.chip_select}};
  assign wr  = |sel & ~i_ctrl.write_strobe_n; // output enable ignored
  assign rd  = |sel & i_ctrl.write_strobe_n & ~i_ctrl.output_enable_n;
  // follow the bus while writing so the value at the first trailing edge is kept
  always @*
    if (wr)
    begin
      lat_d = o_bus;
      lat_l = sel;
    end
  // commit on the end of the write overlap; contents never drop
  always @(negedge wr)
    for (int i = 0; i < 2; i++)
      if (lat_l[i])
        mem[i_addr][i*8+:8] = lat_d[i*8+:8];
  // released lanes show the inverse so a stale value cannot pass
  always @*
    for (int i = 0; i < 2; i++)
      if (!i_dq_oe_n[i])
        o_bus[i*8+:8] = i_dq[i*8+:8];
      else if (rd && sel[i])
        o_bus[i*8+:8] = mem[i_addr][i*8+:8];
      else
        o_bus[i*8+:8] = ~i_dq[i*8+:8];
endmodule // sram_model

// *** test/sram_host_checker.sv ***
// pin and handshake assertions for the sram host controller
`timescale 1ns/1ps
module sram_host_checker
  import sram_host_pkg::*;
#(
  parameter int RECOVERY_CYCLES = 8
)(
  // clock, reset, request side
  input wire logic              i_clock,
  input wire logic              i_resetn,
  input wire logic              i_req_valid,
  input wire sram_req_t         i_req,
  input wire logic              o_req_ready,
  input wire logic              o_rsp_valid,
  // retention and pins
  input wire logic              o_retention_ack,
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire sram_ctrl_t        o_mem_ctrl,
  input wire logic [1:0]        o_mem_dq_oe_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  int unsigned rec_cnt_ff;
  // cycles since retention ended; reset counts as a fresh supply
  always_ff @(posedge i_clock or negedge i_resetn)
    if (!i_resetn)
      rec_cnt_ff <= 0;
    else if (o_retention_ack)
      rec_cnt_ff <= 0;
    else if (rec_cnt_ff < RECOVERY_CYCLES)
      rec_cnt_ff <= rec_cnt_ff + 1;
  sequence s_take;
    i_req_valid && o_req_ready;
  endsequence
  a_read_answer: assert property (s_take ##0 (!i_req.write && i_req.lanes != 2'b00) |-> ##5 o_rsp_valid)
    else $error("read answer not at fifth cycle");
  a_write_strobe: assert property (s_take ##0 (i_req.write && i_req.lanes != 2'b00) |-> ##[2:4] !o_mem_ctrl.write_strobe_n)
    else $error("write strobe missing");
  a_no_lane_idle: assert property (s_take ##0 (i_req.lanes == 2'b00) |=> !o_mem_ctrl.chip_select [*5])
    else $error("access without lanes");
  a_addr_hold: assert property (!o_mem_ctrl.write_strobe_n |-> $stable(o_mem_addr) ##1 $stable(o_mem_addr))
    else $error("address moved in write");
  a_strobe_after_sel: assert property ($fell(o_mem_ctrl.write_strobe_n) |-> $past(o_mem_ctrl.chip_select))
    else $error("strobe fell before select");
  a_strobe_first_up: assert property ($rose(o_mem_ctrl.write_strobe_n) |-> o_mem_ctrl.chip_select && o_mem_dq_oe_n != 2'b11)
    else $error("strobe not first trailing edge");
  a_oe_off_write: assert property (!o_mem_ctrl.write_strobe_n |-> o_mem_ctrl.output_enable_n)
    else $error("output enable low in write");
  a_no_contention: assert property (!o_mem_ctrl.output_enable_n |-> o_mem_dq_oe_n == 2'b11)
    else $error("host drives during read");
  a_retain_off: assert property (o_retention_ack |-> !o_mem_ctrl.chip_select && o_mem_ctrl.lower_lane_select_n
                                 && o_mem_ctrl.upper_lane_select_n)
    else $error("ram selected in retention");
  a_recover_wait: assert property (o_mem_ctrl.chip_select |-> rec_cnt_ff >= RECOVERY_CYCLES)
    else $error("access inside recovery");
endmodule // sram_host_checker

// *** test/sram_host_tb_top.sv ***
// self-checking bench for the sram host controller against a behavioural ram
`timescale 1ns/1ps
module sram_host_tb_top;
  import sram_host_pkg::*;
  localparam int REC = 8;
  localparam logic [ADDR_W-1:0] A = 16'hBEEF;
  logic [ADDR_W-1:0] addr_q = A;
  logic              i_clock = 0, i_resetn = 0, i_req_valid = 0, i_retention_req = 0;
  sram_req_t         i_req = '0;
  logic              o_req_ready, o_rsp_valid, o_retention_ack;
  logic [DATA_W-1:0] o_rsp_data, o_mem_dq, bus, rd;
  logic [ADDR_W-1:0] o_mem_addr;
  sram_ctrl_t        o_mem_ctrl;
  logic [1:0]        o_mem_dq_oe_n;
  int                fail_count = 0, num_checks = 0, cyc = 0;
  sram_host #(.RECOVERY_CYCLES(REC)) u_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
    .i_retention_req(i_retention_req), .o_retention_ack(o_retention_ack), .o_mem_addr(o_mem_addr),
    .o_mem_ctrl(o_mem_ctrl), .i_mem_dq(bus), .o_mem_dq(o_mem_dq), .o_mem_dq_oe_n(o_mem_dq_oe_n));
  sram_model u_ram (.i_addr(o_mem_addr), .i_ctrl(o_mem_ctrl), .i_dq(o_mem_dq), .i_dq_oe_n(o_mem_dq_oe_n), .o_bus(bus));
  initial forever #25 i_clock = ~i_clock;
  // hang guard: the whole run needs about 120 cycles
  always @(posedge i_clock)
    if (++cyc == 2000)
    begin
      fail_count++;
      finish_test();
    end
  task automatic chk(string name, logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one request held until taken, then five cycles to catch a read answer
  task automatic access(logic wr, logic [DATA_W-1:0] d, logic [1:0] ln);
    int n;
    n = 0;
    i_req = '{write: wr, addr: addr_q, wdata: d, lanes: ln};
    i_req_valid = 1;
    while (o_req_ready !== 1'b1 && n++ < 40) @(posedge i_clock) #1;
    @(posedge i_clock) #1;
    i_req_valid = 0;
    rd = 'x;
    repeat (5)
    begin
      @(posedge i_clock) #1;
      if (o_rsp_valid === 1'b1)
        rd = o_rsp_data;
    end
  endtask
  task automatic t_lanes();
    access(1, 16'hA55A, 2'b11);
    access(0, 16'h0000, 2'b11);
    chk("word", rd, 16'hA55A);
    access(1, 16'hFFC3, 2'b01);
    access(0, 16'h0000, 2'b11);
    chk("lower", rd, 16'hA5C3);
    access(1, 16'h3CFF, 2'b10);
    access(0, 16'h0000, 2'b11);
    chk("upper", rd, 16'h3CC3);
    access(0, 16'h0000, 2'b01);
    chk("lower read", rd, 16'h00C3);
    access(1, 16'h0F0F, 2'b00);
    chk("no lanes", rd, 16'hXXXX);
    access(0, 16'h0000, 2'b11);
    chk("unchanged", rd, 16'h3CC3);
    // a second address moves the pins between accesses
    addr_q = 16'h0123;
    access(1, 16'h5AA5, 2'b11);
    access(0, 16'h0000, 2'b11);
    chk("second addr", rd, 16'h5AA5);
    addr_q = A;
    access(0, 16'h0000, 2'b11);
    chk("first addr", rd, 16'h3CC3);
    $display("test lanes done");
  endtask
  task automatic t_retain();
    int n;
    n = 0;
    i_retention_req = 1;
    while (o_retention_ack !== 1'b1 && n++ < 20) @(posedge i_clock) #1;
    chk("ack", {15'h0, o_retention_ack}, 16'h0001);
    chk("ready held", {15'h0, o_req_ready}, 16'h0000);
    i_retention_req = 0;
    n = 0;
    while (o_req_ready !== 1'b1 && n < 40)
    begin
      @(posedge i_clock) #1;
      n++;
    end
    chk("recovery", {15'h0, n >= REC && n < 40}, 16'h0001);
    access(0, 16'h0000, 2'b11);
    chk("retained", rd, 16'h3CC3);
    $display("test retain done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge i_clock);
    #1 i_resetn = 1;
    t_lanes();
    t_retain();
    finish_test();
  end
endmodule // sram_host_tb_top
bind sram_host sram_host_checker #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_chk (.i_clock(i_clock), .i_resetn(i_resetn),
  .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid),
  .o_retention_ack(o_retention_ack), .o_mem_addr(o_mem_addr), .o_mem_ctrl(o_mem_ctrl), .o_mem_dq_oe_n(o_mem_dq_oe_n));
